// ===== rshi_host_if.sv
module rshi_host_if import rshi_pkg::*; #(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_reset_n,
  input wire logic i_input_strobe_n,
  input wire logic [BYTE_W-1:0] i_data_in_bus,
  input wire logic i_erase,
  input wire logic i_output_strobe_n,
  output logic o_input_ready_n,
  output logic o_output_ready_n,
  output logic [BYTE_W-1:0] o_data_out_bus,
  output logic o_correctable_n,
  output logic o_corrected_byte_flag
);
  localparam int unsigned CW = $clog2(DEPTH) + 1;

  function automatic logic over_limit(input logic [7:0] cnt, input logic [7:0] lim);
    over_limit = (cnt > lim);
  endfunction

  logic [7:0] erasure_scale_factor_r;
  logic [7:0] correction_threshold_r;
  logic [7:0] check_symbol_count_r;
  logic [7:0] message_symbol_count_r;
  logic [7:0] block_length_r;
  logic [7:0] control_settings_r;
  logic [2:0] init_idx_r;
  logic [1:0] low_cnt_r;
  logic [1:0] high_cnt_r;
  logic init_open;
  logic running;
  logic take;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [BYTE_W:0] fifo_q;
  logic [CW-1:0] fifo_count;
  logic [7:0] load_cnt_r;
  logic [7:0] ers_cnt_r;
  logic [7:0] ers_total;
  logic blk_full_r;
  logic blk_uncorr_r;
  logic blk_keep_r;
  logic last_byte;
  logic [7:0] wr_addr;
  logic [BYTE_W:0] mem_q;
  rshi_out_st_t out_st_r;
  logic [7:0] rd_addr_r;
  logic [7:0] remain_r;
  logic accept_out;
  logic raw;
  logic correct_vs_vector_sel;
  logic fwd;
  logic suppress_check_out;
  logic [7:0] r_count;

  assign raw = control_settings_r[CTL_RAW];
  assign correct_vs_vector_sel = control_settings_r[CTL_CORRECT_VS_VECTOR_SEL];
  assign fwd = control_settings_r[CTL_FWD];
  assign suppress_check_out = control_settings_r[CTL_SUPPRESS_CHECK_OUT];
  assign r_count = {3'h0, check_symbol_count_r[FIELD_MSB:0]};

  // Reset pin phases
  assign init_open = !i_reset_n && (low_cnt_r == RST_LOW_MIN);
  assign running = i_reset_n && (high_cnt_r == RUN_HIGH_MIN);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
    end else begin
      low_cnt_r <= i_reset_n ? '0 : (init_open ? low_cnt_r : low_cnt_r + 2'h1);
      high_cnt_r <= !i_reset_n ? '0 : (running ? high_cnt_r : high_cnt_r + 2'h1);
    end
  end

  assign take = !i_input_strobe_n && !o_input_ready_n;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_input_ready_n <= 1'b1;
    end else if (init_open) begin
      o_input_ready_n <= !((init_idx_r < IDX_DONE) && !(take && init_idx_r == IDX_CTRL));
    end else if (running) begin
      o_input_ready_n <= !(fifo_count + CW'(take) < CW'(DEPTH));
    end else begin
      o_input_ready_n <= 1'b1;
    end
  end

  // Write-only parameter load, six bytes in order
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      init_idx_r <= '0;
      erasure_scale_factor_r <= REG_RESET;
      correction_threshold_r <= REG_RESET;
      check_symbol_count_r <= REG_RESET;
      message_symbol_count_r <= REG_RESET;
      block_length_r <= REG_RESET;
      control_settings_r <= REG_RESET;
    end else if (i_reset_n) begin
      init_idx_r <= '0;
    end else if (take) begin
      init_idx_r <= init_idx_r + 3'h1;
      case (init_idx_r)
        IDX_SCALE: erasure_scale_factor_r <= i_data_in_bus;
        IDX_THRESH: correction_threshold_r <= {3'h0, i_data_in_bus[FIELD_MSB:0]};
        IDX_CHECK: check_symbol_count_r <= {3'h0, i_data_in_bus[FIELD_MSB:0]};
        IDX_MSG: message_symbol_count_r <= i_data_in_bus;
        IDX_LEN: block_length_r <= i_data_in_bus;
        IDX_CTRL: control_settings_r <= i_data_in_bus;
        default: init_idx_r <= init_idx_r;
      endcase
    end
  end

  assign fifo_push = take && i_reset_n;

  rshi_fifo #(.WIDTH(BYTE_W + 1), .DEPTH(DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clr(!i_reset_n),
    .i_valid(fifo_push),
    .o_ready(fifo_in_ready),
    .i_data({i_erase, i_data_in_bus}),
    .o_valid(fifo_valid),
    .i_ready(out_st_r == RSHI_O_IDLE && !blk_full_r),
    .o_data(fifo_q),
    .o_count(fifo_count)
  );

  // Core moves a block into the output buffer, last arrival at address zero
  assign fifo_pop = fifo_valid && out_st_r == RSHI_O_IDLE && !blk_full_r;
  assign last_byte = (load_cnt_r == block_length_r - 8'h01);
  assign wr_addr = block_length_r - 8'h01 - load_cnt_r;
  assign ers_total = ers_cnt_r + {7'h0, fifo_q[BYTE_W]};

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_reset_n) begin
      load_cnt_r <= '0;
      ers_cnt_r <= '0;
      blk_full_r <= 1'b0;
      blk_uncorr_r <= 1'b0;
      blk_keep_r <= 1'b1;
    end else if (fifo_pop) begin
      load_cnt_r <= last_byte ? '0 : load_cnt_r + 8'h01;
      ers_cnt_r <= last_byte ? '0 : ers_total;
      if (last_byte) begin
        blk_full_r <= 1'b1;
        blk_keep_r <= !(over_limit(ers_total, correction_threshold_r) || over_limit(ers_total, r_count));
        blk_uncorr_r <= control_settings_r[CTL_ERC] &&
          (over_limit(ers_total, correction_threshold_r) || over_limit(ers_total, r_count));
      end
    end else if (out_st_r == RSHI_O_IDLE && blk_full_r) begin
      blk_full_r <= 1'b0;
    end
  end

  rshi_obuf #(.WIDTH(BYTE_W + 1), .AW(ADDR_W)) u_obuf (
    .i_core_clk(i_core_clk),
    .i_we(fifo_pop),
    .i_waddr(wr_addr),
    .i_wdata(fifo_q),
    .i_raddr(rd_addr_r),
    .o_rdata(mem_q)
  );

  // Output side
  assign accept_out = !o_output_ready_n && !i_output_strobe_n;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_reset_n) begin
      out_st_r <= RSHI_O_IDLE;
      rd_addr_r <= '0;
      remain_r <= '0;
      o_output_ready_n <= 1'b1;
    end else begin
      case (out_st_r)
        RSHI_O_IDLE: begin
          if (blk_full_r) begin
            out_st_r <= RSHI_O_FETCH;
            remain_r <= (suppress_check_out && !raw) ? message_symbol_count_r : block_length_r;
            rd_addr_r <= fwd ? block_length_r - 8'h01 : ((suppress_check_out && !raw) ? r_count : 8'h00);
          end
        end
        RSHI_O_FETCH: out_st_r <= RSHI_O_LATCH;
        RSHI_O_LATCH: begin
          out_st_r <= RSHI_O_SHOW;
          o_output_ready_n <= 1'b0;
        end
        RSHI_O_SHOW: begin
          if (accept_out) begin
            o_output_ready_n <= 1'b1;
            remain_r <= remain_r - 8'h01;
            rd_addr_r <= fwd ? rd_addr_r - 8'h01 : rd_addr_r + 8'h01;
            out_st_r <= (remain_r == 8'h01) ? RSHI_O_IDLE : RSHI_O_FETCH;
          end
        end
        default: out_st_r <= RSHI_O_IDLE;
      endcase
    end
  end

  // Output byte, corrected flag and correctable flag
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_data_out_bus <= '0;
      o_corrected_byte_flag <= 1'b0;
      o_correctable_n <= 1'b1;
    end else begin
      if (out_st_r == RSHI_O_LATCH) begin
        if (raw) begin
          o_data_out_bus <= correct_vs_vector_sel ? mem_q[BYTE_W-1:0] : '0;
        end else begin
          o_data_out_bus <= correct_vs_vector_sel ? mem_q[BYTE_W-1:0] : '0;
        end
        o_corrected_byte_flag <= mem_q[BYTE_W] && blk_keep_r && !raw;
      end else if (accept_out) begin
        o_corrected_byte_flag <= 1'b0;
      end
      if (out_st_r == RSHI_O_IDLE && blk_full_r) begin
        o_correctable_n <= blk_uncorr_r;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n || !i_reset_n);

  sequence s_start;
    out_st_r == RSHI_O_IDLE && blk_full_r;
  endsequence

  sequence s_accept_more;
    accept_out && remain_r > 8'h01;
  endsequence

  property p_no_overflow;
    !(fifo_push && !fifo_in_ready);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("input byte taken while buffer full");

  property p_refused_strobe;
    (out_st_r != RSHI_O_IDLE && o_output_ready_n) |=> remain_r == $past(remain_r);
  endproperty
  a_refused_strobe: assert property (p_refused_strobe) else $error("output advanced while not ready");

  property p_advance;
    s_accept_more |=> o_output_ready_n ##1 o_output_ready_n ##1 !o_output_ready_n;
  endproperty
  a_advance: assert property (p_advance) else $error("next output byte not presented in time");

  property p_flag_raw;
    o_corrected_byte_flag |-> !raw;
  endproperty
  a_flag_raw: assert property (p_flag_raw) else $error("corrected flag in raw mode");

  property p_raw_zero;
    (raw && !correct_vs_vector_sel && !o_output_ready_n) |-> o_data_out_bus == '0;
  endproperty
  a_raw_zero: assert property (p_raw_zero) else $error("raw zero output not zero");

  property p_wait_full;
    (out_st_r == RSHI_O_IDLE && !blk_full_r) |=> out_st_r == RSHI_O_IDLE;
  endproperty
  a_wait_full: assert property (p_wait_full) else $error("output started before block complete");

  property p_no_load_drain;
    out_st_r != RSHI_O_IDLE |-> !fifo_pop;
  endproperty
  a_no_load_drain: assert property (p_no_load_drain) else $error("output buffer written while draining");

  property p_correctable;
    s_start |-> ##3 (!o_output_ready_n && o_correctable_n == $past(blk_uncorr_r, 3));
  endproperty
  a_correctable: assert property (p_correctable) else $error("correctable flag wrong at first byte");
endmodule // rshi_host_if

// ===== rshi_pkg.sv
package rshi_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned INIT_COUNT = 6;
  localparam logic [2:0] IDX_SCALE = 3'h0;
  localparam logic [2:0] IDX_THRESH = 3'h1;
  localparam logic [2:0] IDX_CHECK = 3'h2;
  localparam logic [2:0] IDX_MSG = 3'h3;
  localparam logic [2:0] IDX_LEN = 3'h4;
  localparam logic [2:0] IDX_CTRL = 3'h5;
  localparam logic [2:0] IDX_DONE = 3'h6;
  localparam int unsigned FIELD_MSB = 4;
  localparam int unsigned CTL_SUPPRESS_CHECK_OUT = 1;
  localparam int unsigned CTL_CORRECT_VS_VECTOR_SEL = 2;
  localparam int unsigned CTL_FWD = 3;
  localparam int unsigned CTL_RAW = 4;
  localparam int unsigned CTL_ERC = 5;
  localparam logic [1:0] RST_LOW_MIN = 2'h2;
  localparam logic [1:0] RUN_HIGH_MIN = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [3:0] {
    RSHI_O_IDLE = 4'b0001,
    RSHI_O_FETCH = 4'b0010,
    RSHI_O_LATCH = 4'b0100,
    RSHI_O_SHOW = 4'b1000
  } rshi_out_st_t;
endpackage

// ===== rshi_fifo.sv
module rshi_fifo import rshi_pkg::*; #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign o_ready = (count_r != (AW+1)'(DEPTH));
  assign o_valid = (count_r != '0);
  assign o_data = mem_r[rd_ptr_r];
  assign o_count = count_r;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rshi_fifo

// ===== rshi_obuf.sv
module rshi_obuf #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned AW = 8
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_r [2**AW];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem_r[i_raddr];
  end
endmodule // rshi_obuf

// ===== rshi_ctrl_model.sv
module rshi_ctrl_model (
  input wire logic i_core_clk,
  input wire logic i_input_ready_n,
  input wire logic i_output_ready_n,
  input wire logic [7:0] i_data_out_bus,
  input wire logic i_correctable_n,
  input wire logic i_corrected_byte_flag,
  output logic o_reset_n,
  output logic o_input_strobe_n,
  output logic [7:0] o_data_in_bus,
  output logic o_erase,
  output logic o_output_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_reset_n = 1'b1;
    o_input_strobe_n = 1'b1;
    o_data_in_bus = 8'h00;
    o_erase = 1'b0;
    o_output_strobe_n = 1'b1;
  end

  // Offers a byte each cycle; strobes into a busy device only when pest is set
  task automatic send(input logic [7:0] d, input logic e, input bit pest, output bit to);
    int n;
    to = 1'b1;
    for (n = 0; n < 300 && to; n++) begin
      @(posedge i_core_clk);
      #1;
      o_erase = e;
      if (i_input_ready_n === 1'b0) begin
        o_data_in_bus = d;
        o_input_strobe_n = 1'b0;
        to = 1'b0;
      end else begin
        o_data_in_bus = ~d;
        o_input_strobe_n = !pest;
      end
    end
  endtask

  task automatic idle_in();
    @(posedge i_core_clk);
    #1;
    o_input_strobe_n = 1'b1;
    o_data_in_bus = ~o_data_in_bus;
  endtask

  // Parameter load: reset low with strobes idle, six bytes, one more clock low
  task automatic init(input logic [7:0] b [6], output bit to);
    int i;
    bit t;
    to = 1'b0;
    @(posedge i_core_clk);
    #1;
    o_reset_n = 1'b0;
    for (i = 0; i < 6; i++) begin
      send(b[i], 1'b0, 1'b0, t);
      to = to | t;
    end
    idle_in();
    @(posedge i_core_clk);
    #1;
    o_reset_n = 1'b1;
  endtask

  // Takes one output byte when ready on the k-th cycle of the call or later; pulses strobe while not ready
  task automatic recv(input int k, output logic [7:0] d, output logic f, output logic c, output bit to);
    int n;
    logic s;
    to = 1'b1;
    for (n = 0; n < 300 && to; n++) begin
      @(posedge i_core_clk);
      #1;
      s = 1'b1;
      if (i_output_ready_n === 1'b0 && n >= k) begin
        d = i_data_out_bus;
        f = i_corrected_byte_flag;
        c = i_correctable_n;
        s = 1'b0;
        to = 1'b0;
      end else if (i_output_ready_n === 1'b1) begin
        s = n[0];
      end
      o_output_strobe_n = s;
    end
  endtask

  task automatic idle_out();
    @(posedge i_core_clk);
    #1;
    o_output_strobe_n = 1'b1;
  endtask
endmodule // rshi_ctrl_model

// ===== test_rs_codec_host_interface.sv
module test_rs_codec_host_interface import rshi_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int K = 5;
  localparam int R = 4;
  localparam int N = K + R;
  logic clk, rst_n, reset_n, istb_n, erase, ostb_n, irdy_n, ordy_n, crt_n, cflag;
  logic [BYTE_W-1:0] din, dout;
  int fails = 0;
  int checks = 0;
  logic [7:0] cfg [9] = '{8'h0C, 8'h04, 8'h0E, 8'h06, 8'h08, 8'h18, 8'h1E, 8'h2C, 8'h0C};
  int ner [9] = '{1, 2, 0, 1, 1, 1, 2, 5, 5};
  int qd[$], qf[$], qc[$];

  rshi_host_if dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reset_n(reset_n), .i_input_strobe_n(istb_n),
    .i_data_in_bus(din), .i_erase(erase), .i_output_strobe_n(ostb_n), .o_input_ready_n(irdy_n),
    .o_output_ready_n(ordy_n), .o_data_out_bus(dout), .o_correctable_n(crt_n), .o_corrected_byte_flag(cflag));

  rshi_ctrl_model mdl (.i_core_clk(clk), .i_input_ready_n(irdy_n), .i_output_ready_n(ordy_n),
    .i_data_out_bus(dout), .i_correctable_n(crt_n), .i_corrected_byte_flag(cflag), .o_reset_n(reset_n),
    .o_input_strobe_n(istb_n), .o_data_in_bus(din), .o_erase(erase), .o_output_strobe_n(ostb_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tmo();
    fails++;
    finish_test();
  endtask

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  initial begin
    logic [7:0] ib [6];
    logic [7:0] blk [2][N];
    logic er [N];
    logic [7:0] d;
    logic f, c;
    bit to, t2;
    int ci, b, i, j, idx, nout, fwd, seed;
    seed = $urandom(78);
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (ci = 0; ci < 9; ci++) begin
      ib = '{8'h5A, 8'h84, 8'h84, 8'(K), 8'(N), cfg[ci]};
      mdl.init(ib, to);
      if (to) tmo();
      fwd = cfg[ci][3];
      nout = (cfg[ci][1] && !cfg[ci][4]) ? K : N;
      for (i = 0; i < N; i++) er[i] = ((i * 2 + ci) % N) < ner[ci];
      for (b = 0; b < 2; b++) begin
        for (i = 0; i < N; i++) blk[b][i] = 8'($urandom);
        for (j = 0; j < nout; j++) begin
          idx = fwd ? j : nout - 1 - j;
          qd.push_back(cfg[ci][2] ? blk[b][idx] : 0);
          qf.push_back(!cfg[ci][4] && ner[ci] <= R && er[idx]);
          qc.push_back(idx == 0 ? (ner[ci] > R && cfg[ci][5]) : -1);
        end
      end
      fork
        begin
          for (b = 0; b < 2; b++) begin
            for (i = 0; i < N; i++) begin
              mdl.send(blk[b][i], er[i], b + i > 0, t2);
              if (t2) tmo();
            end
          end
          mdl.idle_in();
        end
        begin
          for (j = 0; j < 2 * nout; j++) begin
            mdl.recv($urandom_range(3, 0), d, f, c, to);
            if (to) tmo();
            chk("data_out_bus", d, 8'(qd.pop_front()));
            chk("corrected_byte_flag", {7'h00, f}, 8'(qf.pop_front()));
            idx = qc.pop_front();
            if (idx >= 0) chk("correctable_n", {7'h00, c}, 8'(idx));
          end
          mdl.idle_out();
        end
      join
    end
    finish_test();
  end
endmodule // test_rs_codec_host_interface
